// [sfmc_deglitch.sv]
// symmetric counting deglitch filter, one per input bit
`timescale 1ns/1ps
module sfmc_deglitch #(
    parameter int WIDTH = 5,
    parameter int COUNT = 20000
) (
    input  wire logic             mclk,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] raw,
    output logic      [WIDTH-1:0] filtered
);
    localparam int CW = $clog2(COUNT + 1);
    if (COUNT < 1 || WIDTH < 1) begin : g_bad_param
        $error("sfmc_deglitch: bad parameters");
    end
    typedef struct packed {
        logic [WIDTH-1:0][CW-1:0] cnt;
        logic [WIDTH-1:0]         out;
    } sfmc_dg_state_t;
    sfmc_dg_state_t st, next_st;
    always_comb begin
        next_st = st;
        for (int i = 0; i < WIDTH; i++) begin
            // same delay on both edges; a short glitch just restarts the count
            if (raw[i] == st.out[i]) begin
                next_st.cnt[i] = '0;
            end else if (st.cnt[i] == CW'(COUNT - 1)) begin
                next_st.cnt[i] = '0;
                next_st.out[i] = raw[i];
            end else begin
                next_st.cnt[i] = st.cnt[i] + 1'b1;
            end
        end
    end
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
    assign filtered = st.out;
endmodule

// [sfmc_mcu_model.sv]
// microcontroller side of the shared clock pin
`timescale 1ns/1ps
module sfmc_mcu_model (
    input  wire logic mclk,
    input  wire logic clk_run,
    input  wire logic active_low_reset_pin_n,
    input  wire logic pwm_clk_oe,
    output logic      level
);
    logic lclk = 1'b0;
    logic junk = 1'b0;
    // link clock stands still outside frames
    always #62.5 lclk = clk_run ? ~lclk : 1'b0;
    // released pin shows a changing pattern, not a stale level
    always @(posedge mclk) junk <= ~junk;
    assign level = (clk_run && active_low_reset_pin_n && !pwm_clk_oe) ? lclk : junk;
endmodule

// [sfmc_pkg.sv]
// constants and types for supply and fail mode control
package sfmc_pkg;
    // ****************************************
    // register map (byte addresses)
    // ****************************************
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_FAULT  = 8'h08;
    localparam logic [7:0] ADDR_PWM    = 8'h0C;
    localparam logic [7:0] ADDR_WDOG   = 8'h10;
    localparam logic [7:0] ADDR_ID     = 8'h14;
    // arbitrary value
    localparam logic [31:0] ID_VALUE   = 32'h5F3C_0001;
    // ****************************************
    // control register fields
    // ****************************************
    localparam int CTRL_EXT_BIT   = 0;
    localparam int CTRL_WDSEL_BIT = 1;
    localparam int CTRL_WDTOG_BIT = 2;
    localparam int CTRL_LENERR_BIT = 3;
    // ****************************************
    // status register fields (device status register number seven)
    // ****************************************
    localparam int ST_FAILREQ_BIT = 0;
    localparam int ST_SERFAIL_BIT = 1;
    localparam int ST_MODE_LSB    = 4;
    localparam int ST_SUPPLY_LSB  = 8;
    localparam int ST_GNDLOSS_BIT = 10;
    localparam int ST_WAKE_BIT    = 11;
    localparam int FAULT_W        = 8;
    localparam int CH_W           = 5;
    localparam int DIRECT_W       = 4;
    localparam logic [31:0] RESET_VALUE = 32'h0000_0000;
    localparam logic [31:0] READ_INVALID = 32'hFFFF_FFFF;
    // ****************************************
    // timing
    // ****************************************
    localparam int CLK_MHZ        = 100;
    localparam int DEGLITCH_US    = 200;
    localparam int DEGLITCH_CYC   = DEGLITCH_US * CLK_MHZ;
    localparam int WD_SHORT_MS    = 24;
    localparam int WD_LONG_MS     = 96;
    localparam int WD_SHORT_CYC   = WD_SHORT_MS * 1000 * CLK_MHZ;
    localparam int WD_LONG_CYC    = WD_LONG_MS * 1000 * CLK_MHZ;
    typedef enum logic [2:0] {
        SFMC_OFF,
        SFMC_SLEEP,
        SFMC_SHUT,
        SFMC_FAIL,
        SFMC_NORMAL
    } sfmc_mode_t;
endpackage

// [sfmc_top.sv]
// supply and fail mode control: mode selection, wake report, wishbone registers
`timescale 1ns/1ps
module sfmc_top #(
    parameter int DEGLITCH_CYC = sfmc_pkg::DEGLITCH_CYC,
    parameter int WD_SHORT_CYC = sfmc_pkg::WD_SHORT_CYC,
    parameter int WD_LONG_CYC  = sfmc_pkg::WD_LONG_CYC
) (
    input  wire logic                          mclk,
    input  wire logic                          sys_rst,
    // wishbone slave
    input  wire logic                          wb_cyc_i,
    input  wire logic                          wb_stb_i,
    input  wire logic                          wb_we_i,
    input  wire logic [7:0]                    wb_adr_i,
    input  wire logic [3:0]                    wb_sel_i,
    input  wire logic [31:0]                   wb_dat_i,
    output logic      [31:0]                   wb_dat_o,
    output logic                               wb_ack_o,
    // pins and supply monitors
    input  wire logic                          active_low_reset_pin_n,
    input  wire logic                          wake,
    input  wire logic                          main_supply_ok,
    input  wire logic                          logic_supply_ok,
    input  wire logic                          ground_loss,
    input  wire logic                          fail_request,
    input  wire logic [sfmc_pkg::DIRECT_W-1:0] direct_channel_inputs,
    input  wire logic [sfmc_pkg::FAULT_W-1:0]  fault_events,
    input  wire logic                          pwm_clk_i,
    output logic                               pwm_clk_o,
    output logic                               pwm_clk_oe,
    output logic      [sfmc_pkg::CH_W-1:0]     power_channel_outputs,
    output logic                               external_switch_drive,
    output logic                               serial_failure_flag
);
    localparam int DGW = sfmc_pkg::DIRECT_W + 1;
    localparam int WDW = $clog2(WD_LONG_CYC + 1);
    // refuse counts that the watchdog compare cannot serve
    if (WD_SHORT_CYC < 1 || WD_LONG_CYC < WD_SHORT_CYC) begin : g_bad_wd
        $error("sfmc_top: bad watchdog counts");
    end

    // ****************************************
    // input synchronisers
    // ****************************************
    localparam int SYW = 6 + sfmc_pkg::DIRECT_W + 1 + sfmc_pkg::FAULT_W;
    logic [SYW-1:0] sync_a;
    logic [SYW-1:0] sync_b;
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            sync_a <= '0;
            sync_b <= '0;
        end else begin
            sync_a <= {active_low_reset_pin_n, wake, main_supply_ok, logic_supply_ok, ground_loss,
                       fail_request, direct_channel_inputs, pwm_clk_i, fault_events};
            sync_b <= sync_a;
        end
    end
    logic                          rstpin_n_s, wake_s, main_ok_s, logic_ok_s, gnd_loss_s, pwm_clk_s;
    logic [sfmc_pkg::FAULT_W-1:0]  fault_s;
    logic [DGW-1:0]                dg_raw;
    logic [DGW-1:0]                dg_out;
    assign {rstpin_n_s, wake_s, main_ok_s, logic_ok_s, gnd_loss_s} = sync_b[SYW-1 -: 5];
    assign dg_raw   = sync_b[SYW-6 -: DGW];
    assign pwm_clk_s = sync_b[sfmc_pkg::FAULT_W];
    assign fault_s  = sync_b[sfmc_pkg::FAULT_W-1:0];

    // ****************************************
    // deglitch of fail request and direct inputs
    // ****************************************
    sfmc_deglitch #(
        .WIDTH (DGW),
        .COUNT (DEGLITCH_CYC)
    ) u_deglitch (
        .mclk     (mclk),
        .sys_rst  (sys_rst),
        .raw      (dg_raw),
        .filtered (dg_out)
    );
    logic                          filtered_fail_request;
    logic [sfmc_pkg::DIRECT_W-1:0] direct_f;
    assign filtered_fail_request = dg_out[DGW-1];
    assign direct_f = dg_out[sfmc_pkg::DIRECT_W-1:0];

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        sfmc_pkg::sfmc_mode_t         mode;
        logic [sfmc_pkg::CH_W:0]      pwm_cfg;   // five duty-on bits plus external
        logic [7:0]                   duty;
        logic [7:0]                   pwm_cnt;
        logic                         wd_sel;
        logic                         wd_last;
        logic [WDW-1:0]               wd_cnt;
        logic                         ser_fail;
        logic [sfmc_pkg::FAULT_W-1:0] faults;
        logic                         woke_by_reset;
        logic                         rst_prev;
        logic [sfmc_pkg::CH_W-1:0]    outs;
        logic                         ext;
        logic                         clk_o;
        logic                         clk_oe;
        logic [31:0]                  rdata;
        logic                         ack;
    } sfmc_state_t;
    sfmc_state_t st, next_st;

    logic wb_req;
    logic power_off;
    logic supply_shut;
    logic awake;
    logic wd_limit_hit;
    logic [31:0] ctrl_word;
    logic [31:0] status_word;
    assign wb_req = wb_cyc_i && wb_stb_i && !st.ack;
    assign power_off = !main_ok_s && !logic_ok_s;
    assign supply_shut = gnd_loss_s || !main_ok_s;
    assign awake = wake_s && !power_off;
    assign wd_limit_hit = st.wd_cnt == (st.wd_sel ? WDW'(WD_LONG_CYC) : WDW'(WD_SHORT_CYC));
    assign ctrl_word = {21'h0, st.duty, st.wd_last, st.wd_sel, st.pwm_cfg[0]};
    assign status_word = {20'h0, awake, gnd_loss_s, logic_ok_s, main_ok_s, 1'b0, st.mode, 2'b00,
                          st.ser_fail, filtered_fail_request};

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        next_st = st;
        next_st.ack = 1'b0;
        next_st.rst_prev = rstpin_n_s;
        next_st.faults = st.faults | fault_s;
        // watchdog: counts while logic supply missing too, so timeout follows
        if (st.wd_cnt != '1 && !wd_limit_hit) begin
            next_st.wd_cnt = st.wd_cnt + 1'b1;
        end
        if (wd_limit_hit) begin
            next_st.ser_fail = 1'b1;
        end
        // ****************************************
        // register access; without logic supply reads return invalid data and writes are ignored
        // ****************************************
        if (wb_req) begin
            next_st.ack = 1'b1;
            next_st.rdata = sfmc_pkg::RESET_VALUE;
            if (!logic_ok_s) begin
                next_st.rdata = sfmc_pkg::READ_INVALID;
            end else if (wb_we_i) begin
                case (wb_adr_i)
                    sfmc_pkg::ADDR_CTRL: begin
                        if (wb_sel_i[0]) begin
                            next_st.pwm_cfg[0] = wb_dat_i[sfmc_pkg::CTRL_EXT_BIT];
                            next_st.wd_sel = wb_dat_i[sfmc_pkg::CTRL_WDSEL_BIT];
                            // each control write must toggle the watchdog bit
                            if (wb_dat_i[sfmc_pkg::CTRL_WDTOG_BIT] == st.wd_last ||
                                wb_dat_i[sfmc_pkg::CTRL_LENERR_BIT]) begin
                                next_st.ser_fail = 1'b1;
                            end
                            next_st.wd_last = wb_dat_i[sfmc_pkg::CTRL_WDTOG_BIT];
                            next_st.wd_cnt = '0;
                        end
                    end
                    sfmc_pkg::ADDR_PWM: begin
                        if (wb_sel_i[0]) begin
                            next_st.pwm_cfg[sfmc_pkg::CH_W:1] = wb_dat_i[sfmc_pkg::CH_W-1:0];
                        end
                        if (wb_sel_i[1]) begin
                            next_st.duty = wb_dat_i[15:8];
                        end
                    end
                    sfmc_pkg::ADDR_FAULT: begin
                        // write one to clear; a new event in the same cycle wins
                        if (wb_sel_i[0]) begin
                            next_st.faults = (st.faults & ~wb_dat_i[sfmc_pkg::FAULT_W-1:0]) | fault_s;
                        end
                    end
                    default: begin
                    end
                endcase
            end else begin
                case (wb_adr_i)
                    sfmc_pkg::ADDR_CTRL:   next_st.rdata = ctrl_word;
                    sfmc_pkg::ADDR_STATUS: next_st.rdata = status_word;
                    sfmc_pkg::ADDR_FAULT:  next_st.rdata = {24'h0, st.faults};
                    sfmc_pkg::ADDR_PWM:    next_st.rdata = {16'h0, st.duty, 3'b000, st.pwm_cfg[sfmc_pkg::CH_W:1]};
                    sfmc_pkg::ADDR_WDOG:   next_st.rdata = 32'(st.wd_cnt);
                    sfmc_pkg::ADDR_ID:     next_st.rdata = sfmc_pkg::ID_VALUE;
                    default:               next_st.rdata = sfmc_pkg::RESET_VALUE;
                endcase
            end
        end
        // ****************************************
        // mode selection, highest priority first
        // ****************************************
        if (power_off) begin
            next_st.mode = sfmc_pkg::SFMC_OFF;
        end else if (!wake_s) begin
            next_st.mode = sfmc_pkg::SFMC_SLEEP;
        end else if (supply_shut) begin
            next_st.mode = sfmc_pkg::SFMC_SHUT;
        end else if (filtered_fail_request || st.ser_fail) begin
            next_st.mode = sfmc_pkg::SFMC_FAIL;
        end else begin
            next_st.mode = sfmc_pkg::SFMC_NORMAL;
        end
        // fail to normal needs the flag already low, so no clear: an error in that cycle is kept
        // ****************************************
        // pwm counter, only runs while awake
        // ****************************************
        if (awake) begin
            next_st.pwm_cnt = st.pwm_cnt + 1'b1;
        end
        // ****************************************
        // outputs
        // ****************************************
        next_st.outs = '0;
        next_st.ext = 1'b0;
        case (next_st.mode)
            sfmc_pkg::SFMC_OFF: begin
                next_st.outs = '0;
            end
            sfmc_pkg::SFMC_SLEEP: begin
                next_st.outs = '0;
            end
            sfmc_pkg::SFMC_SHUT: begin
                next_st.outs = '0;
                // external drive only survives a main supply loss, not ground loss
                next_st.ext = !gnd_loss_s && logic_ok_s && st.pwm_cfg[0];
            end
            sfmc_pkg::SFMC_FAIL: begin
                // channel five has no direct input and stays off
                next_st.outs = {1'b0, direct_f};
            end
            sfmc_pkg::SFMC_NORMAL: begin
                for (int i = 0; i < sfmc_pkg::CH_W; i++) begin
                    next_st.outs[i] = st.pwm_cfg[i+1] && (st.pwm_cnt < st.duty);
                end
                next_st.ext = st.pwm_cfg[0];
            end
            default: begin
                next_st.outs = '0;
            end
        endcase
        // ****************************************
        // wake report on the pwm clock pin
        // ****************************************
        if (!rstpin_n_s && st.rst_prev) begin
            next_st.woke_by_reset = 1'b0;
        end
        if (!wake_s) begin
            next_st.woke_by_reset = 1'b0;
        end else if (rstpin_n_s && !st.rst_prev && st.mode == sfmc_pkg::SFMC_SLEEP) begin
            next_st.woke_by_reset = 1'b1;
        end
        if (!rstpin_n_s && awake && main_ok_s && !next_st.woke_by_reset) begin
            next_st.clk_oe = 1'b1;
            next_st.clk_o = 1'b1;
        end else begin
            next_st.clk_oe = 1'b0;
            next_st.clk_o = 1'b0;
        end
        // power off clears everything except the reset pin history
        if (power_off) begin
            next_st = '0;
            next_st.mode = sfmc_pkg::SFMC_OFF;
            next_st.rst_prev = rstpin_n_s;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // all outputs come straight from the state flops
    assign wb_dat_o = st.rdata;
    assign wb_ack_o = st.ack;
    assign pwm_clk_o = st.clk_o;
    assign pwm_clk_oe = st.clk_oe;
    assign power_channel_outputs = st.outs;
    assign external_switch_drive = st.ext;
    assign serial_failure_flag = st.ser_fail;
    logic unused_pwm_clk;
    assign unused_pwm_clk = pwm_clk_s;
endmodule

// [sfmc_top_properties.sv]
// port-level checker for supply and fail mode control
`timescale 1ns/1ps
module sfmc_checker (
    input wire logic        mclk,
    input wire logic        sys_rst,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        active_low_reset_pin_n,
    input wire logic        wake,
    input wire logic        main_supply_ok,
    input wire logic        logic_supply_ok,
    input wire logic        ground_loss,
    input wire logic        pwm_clk_o,
    input wire logic        pwm_clk_oe,
    input wire logic [4:0]  power_channel_outputs,
    input wire logic        external_switch_drive,
    input wire logic        serial_failure_flag
);
    // ****************************************
    // bus and mode relations
    // ****************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    sequence take_s;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence answer_s;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    // eight cycles cover two sync flops plus mode and output registers
    ack_pulse_a: assert property (take_s |=> answer_s) else $error("ack not a single pulse after request");
    ack_idle_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("ack without request");
    off_clear_a: assert property ((!main_supply_ok && !logic_supply_ok)[*8] |->
        (power_channel_outputs == 5'h0_0) && !external_switch_drive && !serial_failure_flag) else $error("power off");
    supply_shut_a: assert property (!main_supply_ok[*8] |-> power_channel_outputs == 5'h0_0)
        else $error("outputs on without main supply");
    supply_nowake_a: assert property (!main_supply_ok[*8] |-> !pwm_clk_oe) else $error("wake report in supply loss");
    ground_off_a: assert property (ground_loss[*8] |-> power_channel_outputs == 5'h0_0)
        else $error("outputs on in ground loss");
    pin_release_a: assert property (active_low_reset_pin_n[*8] |-> !pwm_clk_oe) else $error("clock pin driven");
    clk_high_a: assert property (pwm_clk_oe |-> pwm_clk_o) else $error("clock pin driven low");
    sleep_quiet_a: assert property (!wake[*8] |-> !pwm_clk_oe) else $error("clock pin driven in sleep");
    read_invalid_a: assert property ((!logic_supply_ok[*8]) ##0 (wb_ack_o && !wb_we_i) |->
        wb_dat_o == sfmc_pkg::READ_INVALID) else $error("read valid without logic supply");
endmodule
bind sfmc_top sfmc_checker sfmc_checker_inst (.mclk(mclk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .active_low_reset_pin_n(active_low_reset_pin_n), .wake(wake), .main_supply_ok(main_supply_ok),
    .logic_supply_ok(logic_supply_ok), .ground_loss(ground_loss), .pwm_clk_o(pwm_clk_o),
    .pwm_clk_oe(pwm_clk_oe), .power_channel_outputs(power_channel_outputs),
    .external_switch_drive(external_switch_drive), .serial_failure_flag(serial_failure_flag));

// [sfmc_top_test.sv]
// self-checking bench for supply and fail mode control
`timescale 1ns/1ps
module sfmc_top_test;
    localparam int DEG = 8;
    localparam int WDS = 400;
    logic        mclk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        rst_pin_n = 1'b1;
    logic        wake = 1'b1;
    logic        main_ok = 1'b1;
    logic        logic_ok = 1'b1;
    logic        gnd_loss = 1'b0;
    logic        fail_req = 1'b0;
    logic [3:0]  direct = 4'h0;
    logic [7:0]  faults = 8'h00;
    logic        clk_run = 1'b0;
    logic        mcu_level;
    logic        pin;
    logic        clk_o;
    logic        clk_oe;
    logic [4:0]  outs;
    logic        ext_drv;
    logic        ser_fail;
    int          errors = 0;
    int          checks = 0;
    // ****************************************
    // clock, pin resolution, instances
    // ****************************************
    always #5 mclk = ~mclk;
    assign pin = clk_oe ? clk_o : mcu_level;
    sfmc_top #(.DEGLITCH_CYC(DEG), .WD_SHORT_CYC(WDS), .WD_LONG_CYC(2 * WDS)) sfmc_top_inst (.mclk(mclk),
        .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .active_low_reset_pin_n(rst_pin_n), .wake(wake), .main_supply_ok(main_ok), .logic_supply_ok(logic_ok),
        .ground_loss(gnd_loss), .fail_request(fail_req), .direct_channel_inputs(direct), .fault_events(faults),
        .pwm_clk_i(pin), .pwm_clk_o(clk_o), .pwm_clk_oe(clk_oe), .power_channel_outputs(outs),
        .external_switch_drive(ext_drv), .serial_failure_flag(ser_fail));
    sfmc_mcu_model sfmc_mcu_model_inst (.mclk(mclk), .clk_run(clk_run), .active_low_reset_pin_n(rst_pin_n),
        .pwm_clk_oe(clk_oe), .level(mcu_level));
    // ****************************************
    // shared tasks
    // ****************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge mclk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        do begin
            @(posedge mclk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (wb_ack_o !== 1'b1) errors++;
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_normal;
        logic [31:0] rd;
        int n;
        wb(1'b1, sfmc_pkg::ADDR_CTRL, 32'h0000_0005, rd);
        wb(1'b1, sfmc_pkg::ADDR_PWM, 32'h0000_401F, rd);
        wb(1'b0, sfmc_pkg::ADDR_STATUS, 32'h0000_0000, rd);
        chk({29'h0, rd[6:4]}, 32'h0000_0004);
        // one full 256-cycle period: on while counter below duty 0x40
        n = 0;
        repeat (256) begin
            @(posedge mclk);
            if (outs === 5'h1F) n++;
        end
        chk(n, 32'h0000_0040);
        wb(1'b0, sfmc_pkg::ADDR_CTRL, 32'h0000_0000, rd);
        chk(rd & 32'h0000_0007, 32'h0000_0005);
        wb(1'b0, 8'h40, 32'h0000_0000, rd);
        chk(rd, 32'h0000_0000);
        wb(1'b0, sfmc_pkg::ADDR_ID, 32'h0000_0000, rd);
        chk(rd, sfmc_pkg::ID_VALUE);
        // same toggle value twice counts as a lost frame
        wb(1'b1, sfmc_pkg::ADDR_CTRL, 32'h0000_0005, rd);
        cyc(4);
        chk({31'h0, ser_fail}, 32'h0000_0001);
        $display("normal and serial error test done");
    endtask
    task automatic t_supply;
        logic [31:0] rd;
        main_ok <= 1'b0;
        rst_pin_n <= 1'b0;
        cyc(8);
        chk({27'h0, outs}, 32'h0000_0000);
        chk({31'h0, ext_drv}, 32'h0000_0001);
        chk({31'h0, clk_oe}, 32'h0000_0000);
        // only the logic supply missing: the bus still answers, with invalid data
        main_ok <= 1'b1;
        logic_ok <= 1'b0;
        cyc(8);
        wb(1'b0, sfmc_pkg::ADDR_STATUS, 32'h0000_0000, rd);
        chk(rd, sfmc_pkg::READ_INVALID);
        main_ok <= 1'b0;
        cyc(8);
        chk({25'h0, outs, ext_drv, ser_fail}, 32'h0000_0000);
        main_ok <= 1'b1;
        rst_pin_n <= 1'b1;
        cyc(WDS + 20);
        chk({31'h0, ser_fail}, 32'h0000_0001);
        logic_ok <= 1'b1;
        $display("supply loss test done");
    endtask
    task automatic t_fault;
        logic [31:0] rd;
        faults <= 8'h81;
        cyc(4);
        faults <= 8'h00;
        wb(1'b0, sfmc_pkg::ADDR_FAULT, 32'h0000_0000, rd);
        chk(rd, 32'h0000_0081);
        wb(1'b1, sfmc_pkg::ADDR_FAULT, 32'h0000_0001, rd);
        wb(1'b0, sfmc_pkg::ADDR_FAULT, 32'h0000_0000, rd);
        chk(rd, 32'h0000_0080);
        $display("fault report test done");
    endtask
    task automatic t_fail;
        logic [31:0] rd;
        // power cycle clears the serial failure, so fail mode below comes from the request alone
        main_ok <= 1'b0;
        logic_ok <= 1'b0;
        cyc(8);
        main_ok <= 1'b1;
        logic_ok <= 1'b1;
        cyc(4);
        wb(1'b1, sfmc_pkg::ADDR_CTRL, 32'h0000_0006, rd);
        chk({31'h0, ser_fail}, 32'h0000_0000);
        fail_req <= 1'b1;
        direct <= 4'hA;
        cyc(DEG + 12);
        chk({27'h0, outs}, 32'h0000_000A);
        wb(1'b0, sfmc_pkg::ADDR_STATUS, 32'h0000_0000, rd);
        chk({31'h0, rd[0]}, 32'h0000_0001);
        chk({29'h0, rd[6:4]}, 32'h0000_0003);
        logic_ok <= 1'b0;
        cyc(8);
        chk({27'h0, outs}, 32'h0000_000A);
        gnd_loss <= 1'b1;
        cyc(8);
        chk({27'h0, outs}, 32'h0000_0000);
        gnd_loss <= 1'b0;
        logic_ok <= 1'b1;
        fail_req <= 1'b0;
        direct <= 4'h0;
        $display("fail mode test done");
    endtask
    task automatic t_clk;
        clk_run <= 1'b1;
        cyc(40);
        chk({31'h0, clk_oe}, 32'h0000_0000);
        clk_run <= 1'b0;
        rst_pin_n <= 1'b0;
        cyc(8);
        chk({30'h0, clk_oe, clk_o}, 32'h0000_0003);
        wake <= 1'b0;
        cyc(8);
        chk({26'h0, clk_oe, outs}, 32'h0000_0000);
        wake <= 1'b1;
        rst_pin_n <= 1'b1;
        $display("wake report test done");
    endtask
    task automatic summarize;
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        cyc(20);
        sys_rst <= 1'b0;
        // supply levels need the two sync flops before a request is answered
        cyc(4);
        t_normal;
        t_supply;
        t_fault;
        t_fail;
        t_clk;
        summarize;
    end
    // hang guard, well beyond the thousand or so cycles the tests use
    initial begin
        cyc(3000);
        errors++;
        summarize;
    end
endmodule
